// [pom_port_mux.v]
// Pin function selection for ports 4 low, 5, 6, 7 and port 8 bit 6.
`timescale 1ns/1ps
module pom_port_mux
(
    clk_sys,
    rst,
    port4_dir,
    port4_data,
    port5_dir,
    port5_data,
    port6_dir,
    port6_data,
    port8_bit6_direction,
    port8_bit6_data,
    sci2_clock_out_valid,
    sci2_clock_out,
    i2c1_data_out_valid,
    i2c1_data_out,
    timer0_out_valid,
    timer0_out,
    serial_rx_enable,
    sci2_tx_out_valid,
    sci2_tx_out,
    i2c0_clock_out_valid,
    i2c0_clock_out,
    fifo_uart_pin_output_en,
    host_fifo_uart_en,
    fifo_uart_tx_out,
    sci1_clock_out_valid,
    sci1_clock_out,
    i2c1_clock_out_valid,
    i2c1_clock_out,
    cycle_meas_input_en,
    key_mask_reg,
    irq7_source_sel,
    irq7_enable_bit,
    irq_vector_sel,
    irq6_enable_bit,
    irq5_source_sel,
    irq5_enable_bit,
    port4_pin_i,
    port5_pin_i,
    port6_pin_i,
    port7_pin_i,
    port8_bit6_pin_i,
    port4_pin_o,
    port4_pin_oe,
    port5_pin_o,
    port5_pin_oe,
    port6_pin_o,
    port6_pin_oe,
    port8_bit6_pin_o,
    port8_bit6_pin_oe,
    port4_in,
    port5_in,
    port6_in,
    port7_in,
    port8_bit6_in,
    analog_chan_in,
    sci2_clock_in,
    i2c1_data_in,
    cycle_meas_in1,
    sci2_rx_in,
    i2c0_clock_in,
    fifo_uart_pins_on,
    fifo_uart_rx_in,
    key_wake_in,
    irq7_in,
    irq6_in,
    irq5_in,
    sci1_clock_in,
    i2c1_clock_in
);
`include "pom_defines.vh"
    input  wire       clk_sys;
    input  wire       rst;
    input  wire [3:0] port4_dir;
    input  wire [3:0] port4_data;
    input  wire [2:0] port5_dir;
    input  wire [2:0] port5_data;
    input  wire [7:0] port6_dir;
    input  wire [7:0] port6_data;
    input  wire       port8_bit6_direction;
    input  wire       port8_bit6_data;
    input  wire       sci2_clock_out_valid;
    input  wire       sci2_clock_out;
    input  wire       i2c1_data_out_valid;
    input  wire       i2c1_data_out;
    input  wire       timer0_out_valid;
    input  wire       timer0_out;
    input  wire       serial_rx_enable;
    input  wire       sci2_tx_out_valid;
    input  wire       sci2_tx_out;
    input  wire       i2c0_clock_out_valid;
    input  wire       i2c0_clock_out;
    input  wire       fifo_uart_pin_output_en;
    input  wire       host_fifo_uart_en;
    input  wire       fifo_uart_tx_out;
    input  wire       sci1_clock_out_valid;
    input  wire       sci1_clock_out;
    input  wire       i2c1_clock_out_valid;
    input  wire       i2c1_clock_out;
    input  wire       cycle_meas_input_en;
    input  wire [7:0] key_mask_reg;
    input  wire       irq7_source_sel;
    input  wire       irq7_enable_bit;
    input  wire       irq_vector_sel;
    input  wire       irq6_enable_bit;
    input  wire       irq5_source_sel;
    input  wire       irq5_enable_bit;
    input  wire [3:0] port4_pin_i;
    input  wire [2:0] port5_pin_i;
    input  wire [7:0] port6_pin_i;
    input  wire [7:0] port7_pin_i;
    input  wire       port8_bit6_pin_i;
    output wire [3:0] port4_pin_o;
    output wire [3:0] port4_pin_oe;
    output wire [2:0] port5_pin_o;
    output wire [2:0] port5_pin_oe;
    output reg  [7:0] port6_pin_o;
    output reg  [7:0] port6_pin_oe;
    output wire       port8_bit6_pin_o;
    output wire       port8_bit6_pin_oe;
    output reg  [3:0] port4_in;
    output reg  [2:0] port5_in;
    output reg  [7:0] port6_in;
    output reg  [7:0] port7_in;
    output reg        port8_bit6_in;
    output reg  [7:0] analog_chan_in;
    output reg        sci2_clock_in;
    output reg        i2c1_data_in;
    output reg        cycle_meas_in1;
    output reg        sci2_rx_in;
    output reg        i2c0_clock_in;
    output wire       fifo_uart_pins_on;
    output reg        fifo_uart_rx_in;
    output reg  [7:0] key_wake_in;
    output reg        irq7_in;
    output reg        irq6_in;
    output reg        irq5_in;
    output reg        sci1_clock_in;
    output reg        i2c1_clock_in;

    wire       rx2_sel;
    wire       fifo_rx_sel;
    wire [7:0] key_wake_nxt;

    assign fifo_uart_pins_on = fifo_uart_pin_output_en | host_fifo_uart_en;
    // Receive selection for P4.1 is exclusive with timer ownership.
    assign rx2_sel = serial_rx_enable & ~timer0_out_valid;
    // An input-only function forces the output driver off through a peripheral slot: A for P5.1, B for P4.1.
    assign fifo_rx_sel = fifo_uart_pins_on;

    pom_pin_cell u_p43 (.clk_sys(clk_sys), .rst(rst),
        .per_a_valid(sci2_clock_out_valid), .per_a_data(sci2_clock_out), .per_a_od(1'b0),
        .per_b_valid(1'b0), .per_b_data(1'b0), .per_b_od(1'b0),
        .port_dir(port4_dir[3]), .port_data(port4_data[3]),
        .pin_o(port4_pin_o[3]), .pin_oe(port4_pin_oe[3]), .owner());
    pom_pin_cell u_p42 (.clk_sys(clk_sys), .rst(rst),
        .per_a_valid(i2c1_data_out_valid), .per_a_data(i2c1_data_out), .per_a_od(1'b1),
        .per_b_valid(1'b0), .per_b_data(1'b0), .per_b_od(1'b0),
        .port_dir(port4_dir[2]), .port_data(port4_data[2]),
        .pin_o(port4_pin_o[2]), .pin_oe(port4_pin_oe[2]), .owner());
    // Receive owns the pin with output off: open-drain, data high.
    pom_pin_cell u_p41 (.clk_sys(clk_sys), .rst(rst),
        .per_a_valid(timer0_out_valid), .per_a_data(timer0_out), .per_a_od(1'b0),
        .per_b_valid(serial_rx_enable), .per_b_data(1'b1), .per_b_od(1'b1),
        .port_dir(port4_dir[1]), .port_data(port4_data[1]),
        .pin_o(port4_pin_o[1]), .pin_oe(port4_pin_oe[1]), .owner());
    pom_pin_cell u_p40 (.clk_sys(clk_sys), .rst(rst),
        .per_a_valid(sci2_tx_out_valid), .per_a_data(sci2_tx_out), .per_a_od(1'b0),
        .per_b_valid(1'b0), .per_b_data(1'b0), .per_b_od(1'b0),
        .port_dir(port4_dir[0]), .port_data(port4_data[0]),
        .pin_o(port4_pin_o[0]), .pin_oe(port4_pin_oe[0]), .owner());
    pom_pin_cell u_p52 (.clk_sys(clk_sys), .rst(rst),
        .per_a_valid(i2c0_clock_out_valid), .per_a_data(i2c0_clock_out), .per_a_od(1'b1),
        .per_b_valid(1'b0), .per_b_data(1'b0), .per_b_od(1'b0),
        .port_dir(port5_dir[2]), .port_data(port5_data[2]),
        .pin_o(port5_pin_o[2]), .pin_oe(port5_pin_oe[2]), .owner());
    pom_pin_cell u_p51 (.clk_sys(clk_sys), .rst(rst),
        .per_a_valid(fifo_rx_sel), .per_a_data(1'b1), .per_a_od(1'b1),
        .per_b_valid(1'b0), .per_b_data(1'b0), .per_b_od(1'b0),
        .port_dir(port5_dir[1]), .port_data(port5_data[1]),
        .pin_o(port5_pin_o[1]), .pin_oe(port5_pin_oe[1]), .owner());
    pom_pin_cell u_p50 (.clk_sys(clk_sys), .rst(rst),
        .per_a_valid(fifo_uart_pins_on), .per_a_data(fifo_uart_tx_out), .per_a_od(1'b0),
        .per_b_valid(1'b0), .per_b_data(1'b0), .per_b_od(1'b0),
        .port_dir(port5_dir[0]), .port_data(port5_data[0]),
        .pin_o(port5_pin_o[0]), .pin_oe(port5_pin_oe[0]), .owner());
    pom_pin_cell u_p86 (.clk_sys(clk_sys), .rst(rst),
        .per_a_valid(sci1_clock_out_valid), .per_a_data(sci1_clock_out), .per_a_od(1'b0),
        .per_b_valid(i2c1_clock_out_valid), .per_b_data(i2c1_clock_out), .per_b_od(1'b1),
        .port_dir(port8_bit6_direction), .port_data(port8_bit6_data),
        .pin_o(port8_bit6_pin_o), .pin_oe(port8_bit6_pin_oe), .owner());

    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1)
        begin : g_wake
            assign key_wake_nxt[k] = (key_mask_reg[k] == `POM_BIT_OFF) ? port6_pin_i[k]
                                                                      : `POM_BIT_ON;
        end
    endgenerate

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            port6_pin_o    <= `POM_DIR_RESET;
            port6_pin_oe   <= `POM_DIR_RESET;
            port4_in       <= `POM_P4_RESET;
            port5_in       <= `POM_P5_RESET;
            port6_in       <= `POM_DIR_RESET;
            port7_in       <= `POM_DIR_RESET;
            port8_bit6_in  <= `POM_BIT_OFF;
            analog_chan_in <= `POM_DIR_RESET;
            sci2_clock_in  <= `POM_BIT_ON;
            i2c1_data_in   <= `POM_BIT_ON;
            cycle_meas_in1 <= `POM_BIT_OFF;
            sci2_rx_in     <= `POM_BIT_ON;
            i2c0_clock_in  <= `POM_BIT_ON;
            fifo_uart_rx_in <= `POM_BIT_ON;
            key_wake_in    <= `POM_IDLE_HIGH;
            irq7_in        <= `POM_BIT_ON;
            irq6_in        <= `POM_BIT_ON;
            irq5_in        <= `POM_BIT_ON;
            sci1_clock_in  <= `POM_BIT_ON;
            i2c1_clock_in  <= `POM_BIT_ON;
        end
        else
        begin
            port6_pin_o    <= port6_data;
            port6_pin_oe   <= port6_dir;
            port4_in       <= port4_pin_i;
            port5_in       <= port5_pin_i;
            port6_in       <= port6_pin_i;
            port7_in       <= port7_pin_i;
            analog_chan_in <= port7_pin_i;
            port8_bit6_in  <= port8_bit6_pin_i;
            sci2_clock_in  <= port4_pin_i[3];
            i2c1_data_in   <= port4_pin_i[2];
            cycle_meas_in1 <= cycle_meas_input_en ? port4_pin_i[2] : `POM_BIT_OFF;
            sci2_rx_in     <= rx2_sel ? port4_pin_i[1] : `POM_BIT_ON;
            i2c0_clock_in  <= port5_pin_i[2];
            fifo_uart_rx_in <= fifo_rx_sel ? port5_pin_i[1] : `POM_BIT_ON;
            key_wake_in    <= key_wake_nxt;
            // Interrupt inputs idle high (inactive) when the pin is not routed.
            irq7_in <= (!irq7_source_sel && irq7_enable_bit) ? port6_pin_i[7]
                                                              : `POM_BIT_ON;
            irq6_in <= (!irq_vector_sel && irq6_enable_bit) ? port6_pin_i[6]
                                                             : `POM_BIT_ON;
            irq5_in <= (!irq5_source_sel && irq5_enable_bit) ? port8_bit6_pin_i
                                                              : `POM_BIT_ON;
            sci1_clock_in  <= port8_bit6_pin_i;
            i2c1_clock_in  <= port8_bit6_pin_i;
        end
    end
endmodule

// [pom_defines.vh]
// Constants for the port output priority multiplexer.
// How it works
// - A peripheral output-valid input is 1 while that peripheral owns the pin output.
// - P4.3: serial 2 clock owns pin when its valid is 1, else direction bit.
// - P4.2: I2C 1 data owns pin when its valid is 1, else direction bit.
// - P4.2 feeds cycle-measurement input 1 whenever its input-enable is 1.
// - P4.2 drives low only as I2C data, push-pull as port output.
// - P4.1: timer 0 output, serial 2 receive input, else direction bit.
// - P4.0: serial 2 transmit output when its valid is 1, else direction bit.
// - P5.2: I2C 0 clock when its valid is 1, else direction bit.
// - P5.2 drives low only as I2C clock, push-pull as port output.
// - FIFO-UART pins on is OR of pin output enable and host enable.
// - P5.1: FIFO-UART receive input when pins on, else direction bit.
// - P5.0: FIFO-UART transmit output when pins on, else direction bit.
// - Port 6 follows direction bits; each pin feeds key wake when mask is 0.
// - P6.7 feeds interrupt 7 when source select is 0 and enable is 1.
// - P6.6 feeds interrupt 6 when vector select is 0 and enable is 1.
// - Port 7 pins are input only, serving analog channel and general input.
// - P8.6: serial 1 clock, or I2C 1 clock, exclusive valids, else direction.
// - P8.6 open-drain as I2C clock, push-pull as port or serial clock.
// - P8.6 feeds interrupt 5 when source select is 0 and enable is 1.
`ifndef POM_DEFINES_VH
`define POM_DEFINES_VH
`define POM_DIR_RESET  8'h00
`define POM_BIT_OFF    1'b0
`define POM_BIT_ON     1'b1
`define POM_OWN_PORT   2'h0
`define POM_OWN_PERA   2'h1
`define POM_OWN_PERB   2'h2
`define POM_P4_RESET   4'h0
`define POM_P5_RESET   3'h0
`define POM_IDLE_HIGH  8'hFF
`endif

// [pom_pin_cell.v]
// One multiplexed pin: priority between two peripherals and the port latch.
`timescale 1ns/1ps
module pom_pin_cell
(
    clk_sys,
    rst,
    per_a_valid,
    per_a_data,
    per_a_od,
    per_b_valid,
    per_b_data,
    per_b_od,
    port_dir,
    port_data,
    pin_o,
    pin_oe,
    owner
);
`include "pom_defines.vh"
    input  wire       clk_sys;
    input  wire       rst;
    input  wire       per_a_valid;
    input  wire       per_a_data;
    input  wire       per_a_od;
    input  wire       per_b_valid;
    input  wire       per_b_data;
    input  wire       per_b_od;
    input  wire       port_dir;
    input  wire       port_data;
    output reg        pin_o;
    output reg        pin_oe;
    output reg  [1:0] owner;

    reg       pin_o_nxt;
    reg       pin_oe_nxt;
    reg [1:0] owner_nxt;

    // Peripheral A wins only when B is idle, B only when A is idle; both set falls to port.
    always @*
    begin
        pin_o_nxt  = port_data;
        pin_oe_nxt = port_dir;
        owner_nxt  = `POM_OWN_PORT;
        if (per_a_valid && !per_b_valid)
        begin
            owner_nxt = `POM_OWN_PERA;
            // Open-drain drives only a low level; high releases the pin.
            pin_o_nxt  = per_a_od ? `POM_BIT_OFF : per_a_data;
            pin_oe_nxt = per_a_od ? ~per_a_data : `POM_BIT_ON;
        end
        else if (per_b_valid && !per_a_valid)
        begin
            owner_nxt = `POM_OWN_PERB;
            pin_o_nxt  = per_b_od ? `POM_BIT_OFF : per_b_data;
            pin_oe_nxt = per_b_od ? ~per_b_data : `POM_BIT_ON;
        end
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin_o  <= `POM_BIT_OFF;
            pin_oe <= `POM_BIT_OFF;
            owner  <= `POM_OWN_PORT;
        end
        else
        begin
            pin_o  <= pin_o_nxt;
            pin_oe <= pin_oe_nxt;
            owner  <= owner_nxt;
        end
    end
endmodule

// [pom_port_mux_assertions.sv]
// Port-level checks for the pin multiplexer.
`timescale 1ns/1ps
module pom_port_mux_assertions
(
    input wire       clk_sys,
    input wire       rst,
    input wire [3:0] port4_pin_o,
    input wire [3:0] port4_pin_oe,
    input wire [3:0] port4_pin_i,
    input wire [2:0] port5_pin_oe,
    input wire [7:0] port6_dir,
    input wire [7:0] port6_pin_oe,
    input wire       port8_bit6_pin_oe,
    input wire       sci2_clock_out_valid,
    input wire       sci2_clock_out,
    input wire       i2c1_data_out_valid,
    input wire       i2c1_data_out,
    input wire       fifo_uart_pins_on,
    input wire       fifo_uart_pin_output_en,
    input wire       host_fifo_uart_en,
    input wire       timer0_out_valid,
    input wire       serial_rx_enable,
    input wire       sci2_rx_in
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_rx_sel;
        serial_rx_enable && !timer0_out_valid;
    endsequence
    sequence s_tmr_sel;
        timer0_out_valid && !serial_rx_enable;
    endsequence
    a_sck2_owns_pin: assert property (
        sci2_clock_out_valid |=> port4_pin_oe[3] && port4_pin_o[3] == $past(sci2_clock_out))
        else $error("serial clock does not own its pin");
    a_sda_open_drain: assert property (
        i2c1_data_out_valid |=> !port4_pin_o[2] && port4_pin_oe[2] != $past(i2c1_data_out))
        else $error("data pin not driven low only");
    a_fifo_enable_or: assert property (
        fifo_uart_pins_on == (fifo_uart_pin_output_en | host_fifo_uart_en))
        else $error("fifo pin enable wrong");
    a_fifo_rx_input: assert property (
        fifo_uart_pins_on |=> !port5_pin_oe[1])
        else $error("fifo receive pin driven");
    a_timer_owns_pin: assert property (
        s_tmr_sel |=> port4_pin_oe[1])
        else $error("timer output not driven");
    a_rx_routed: assert property (
        s_rx_sel |=> !port4_pin_oe[1] && sci2_rx_in == $past(port4_pin_i[1]))
        else $error("receive pin not routed");
    a_port6_follows: assert property (
        1'b1 |=> port6_pin_oe == $past(port6_dir))
        else $error("port 6 enable does not follow direction");
    a_reset_inputs: assert property (disable iff (1'b0)
        rst |-> port4_pin_oe == 4'h0 && port6_pin_oe == 8'h00 && !port8_bit6_pin_oe)
        else $error("pin driven during reset");
endmodule

// [pom_pin_world.sv]
// Package pins seen from outside: external drivers, pull-ups and idle lines.
`timescale 1ns/1ps
module pom_pin_world
(
    input  wire        clk_sys,
    input  wire [23:0] drv_o,
    input  wire [23:0] drv_oe,
    input  wire [23:0] ext_val,
    input  wire [23:0] ext_en,
    output wire [23:0] lvl
);
    // The I2C lines are pulled up; other idle lines toggle so no stale level survives.
    localparam [23:0] PULL_UP = 24'h0000C4;
    logic [23:0] flt_r = 24'h5A5A5A;
    always @(negedge clk_sys)
        flt_r <= ~flt_r;
    assign lvl = (drv_oe & drv_o) | (~drv_oe & ext_en & ext_val)
               | (~drv_oe & ~ext_en & (flt_r | PULL_UP));
endmodule

// [tb_top.sv]
// Random self-checking bench for the pin multiplexer.
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0;
    logic rst;
    logic [3:0] port4_dir, port4_data, port4_pin_o, port4_pin_oe, port4_in;
    logic [2:0] port5_dir, port5_data, port5_pin_o, port5_pin_oe, port5_in;
    logic [7:0] port6_dir, port6_data, port6_pin_o, port6_pin_oe, port6_in, port7_in;
    logic [7:0] key_mask_reg, analog_chan_in, key_wake_in;
    logic port8_bit6_direction, port8_bit6_data, port8_bit6_pin_o, port8_bit6_pin_oe;
    logic sci2_clock_out_valid, sci2_clock_out, i2c1_data_out_valid, i2c1_data_out;
    logic timer0_out_valid, timer0_out, serial_rx_enable, sci2_tx_out_valid, sci2_tx_out;
    logic i2c0_clock_out_valid, i2c0_clock_out, fifo_uart_pin_output_en, host_fifo_uart_en;
    logic fifo_uart_tx_out, sci1_clock_out_valid, sci1_clock_out, i2c1_clock_out_valid;
    logic i2c1_clock_out, cycle_meas_input_en, irq7_source_sel, irq7_enable_bit;
    logic irq_vector_sel, irq6_enable_bit, irq5_source_sel, irq5_enable_bit;
    logic port8_bit6_in, sci2_clock_in, i2c1_data_in, cycle_meas_in1, sci2_rx_in;
    logic i2c0_clock_in, fifo_uart_pins_on, fifo_uart_rx_in, irq7_in, irq6_in, irq5_in;
    logic sci1_clock_in, i2c1_clock_in;
    wire  [3:0] port4_pin_i;
    wire  [2:0] port5_pin_i;
    wire  [7:0] port6_pin_i, port7_pin_i;
    wire        port8_bit6_pin_i;
    logic [23:0] xv, xe;
    logic [127:0] rv;
    logic [82:0] q[$];
    int miscompares = 0;
    int check_count = 0;
    int n;

    always #5 clk_sys = ~clk_sys;

    pom_port_mux dut (.*);

    pom_pin_world u_pins (.clk_sys(clk_sys), .ext_val(xv), .ext_en(xe),
        .drv_o({8'h00, port6_pin_o, port8_bit6_pin_o, port5_pin_o, port4_pin_o}),
        .drv_oe({8'h00, port6_pin_oe, port8_bit6_pin_oe, port5_pin_oe, port4_pin_oe}),
        .lvl({port7_pin_i, port6_pin_i, port8_bit6_pin_i, port5_pin_i, port4_pin_i}));

    task final_report;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task put(input logic [112:0] v);
        {xv, xe, port4_dir, port4_data, port5_dir, port5_data, port6_dir, port6_data,
         port8_bit6_direction, port8_bit6_data, sci2_clock_out_valid, sci2_clock_out,
         i2c1_data_out_valid, i2c1_data_out, timer0_out_valid, timer0_out, serial_rx_enable,
         sci2_tx_out_valid, sci2_tx_out, i2c0_clock_out_valid, i2c0_clock_out,
         fifo_uart_pin_output_en, host_fifo_uart_en, fifo_uart_tx_out, sci1_clock_out_valid,
         sci1_clock_out, i2c1_clock_out_valid, i2c1_clock_out, cycle_meas_input_en,
         key_mask_reg, irq7_source_sel, irq7_enable_bit, irq_vector_sel, irq6_enable_bit,
         irq5_source_sel, irq5_enable_bit} = v;
    endtask

    // Returns drive and enable of one pin; an input pin shows neither.
    function automatic logic [1:0] pe(input logic v, d, od, dir, pd);
        pe = v ? (od ? {1'b0, ~d} : {d, 1'b1}) : {pd & dir, dir};
    endfunction

    function automatic logic [31:0] pins();
        logic [15:0] o, oe;
        o = {port6_pin_o, port8_bit6_pin_o, port5_pin_o, port4_pin_o};
        oe = {port6_pin_oe, port8_bit6_pin_oe, port5_pin_oe, port4_pin_oe};
        for (int k = 0; k < 16; k++)
            pins[2 * k +: 2] = {o[k] & oe[k], oe[k]};
    endfunction

    task predict;
        logic t, r, on, s, c;
        logic [31:0] eo;
        logic [18:0] ep;
        t = timer0_out_valid;
        r = serial_rx_enable;
        on = fifo_uart_pin_output_en | host_fifo_uart_en;
        s = sci1_clock_out_valid;
        c = i2c1_clock_out_valid;
        eo[1:0] = pe(sci2_tx_out_valid, sci2_tx_out, 1'b0, port4_dir[0], port4_data[0]);
        eo[3:2] = pe(t ^ r, t ? timer0_out : 1'b1, r, port4_dir[1], port4_data[1]);
        eo[5:4] = pe(i2c1_data_out_valid, i2c1_data_out, 1'b1, port4_dir[2], port4_data[2]);
        eo[7:6] = pe(sci2_clock_out_valid, sci2_clock_out, 1'b0, port4_dir[3], port4_data[3]);
        eo[9:8] = pe(on, fifo_uart_tx_out, 1'b0, port5_dir[0], port5_data[0]);
        eo[11:10] = pe(on, 1'b1, 1'b1, port5_dir[1], port5_data[1]);
        eo[13:12] = pe(i2c0_clock_out_valid, i2c0_clock_out, 1'b1, port5_dir[2], port5_data[2]);
        eo[15:14] = pe(s ^ c, s ? sci1_clock_out : i2c1_clock_out, c,
                       port8_bit6_direction, port8_bit6_data);
        for (int k = 0; k < 8; k++)
            eo[16 + 2 * k +: 2] = pe(1'b0, 1'b0, 1'b0, port6_dir[k], port6_data[k]);
        ep = {port4_pin_i[3:2], cycle_meas_input_en & port4_pin_i[2],
              (r & ~t) ? port4_pin_i[1] : 1'b1, port5_pin_i[2], on ? port5_pin_i[1] : 1'b1,
              key_mask_reg | port6_pin_i,
              (~irq7_source_sel & irq7_enable_bit) ? port6_pin_i[7] : 1'b1,
              (~irq_vector_sel & irq6_enable_bit) ? port6_pin_i[6] : 1'b1,
              (~irq5_source_sel & irq5_enable_bit) ? port8_bit6_pin_i : 1'b1,
              port8_bit6_pin_i, port8_bit6_pin_i};
        q.push_back({ep, port4_pin_i, port5_pin_i, port6_pin_i, port7_pin_i,
                     port8_bit6_pin_i, port7_pin_i, eo});
    endtask

    task compare;
        logic [82:0] e;
        logic [31:0] ao;
        logic [18:0] ap;
        e = q.pop_front();
        ao = pins();
        ap = {sci2_clock_in, i2c1_data_in, cycle_meas_in1, sci2_rx_in, i2c0_clock_in,
              fifo_uart_rx_in, key_wake_in, irq7_in, irq6_in, irq5_in, sci1_clock_in,
              i2c1_clock_in};
        check(ao[1:0], e[1:0]);
        check(ao[3:2], e[3:2]);
        check(ao[5:4], e[5:4]);
        check(ao[7:6], e[7:6]);
        check(ao[13:8], e[13:8]);
        check(ao[15:14], e[15:14]);
        check(ao[31:16], e[31:16]);
        check({port4_in, port5_in, port6_in, port7_in, port8_bit6_in, analog_chan_in},
              e[63:32]);
        check(ap[18:13], e[82:77]);
        check(ap[12:0], e[76:64]);
        check(fifo_uart_pins_on, fifo_uart_pin_output_en | host_fifo_uart_en);
    endtask

    task rst_phase;
        rst = 1'b1;
        repeat (3)
        begin
            @(negedge clk_sys);
            #1 check(pins(), 64'h0);
            check({port4_in, port5_in, port6_in, port7_in, port8_bit6_in,
                   analog_chan_in}, 64'h0);
            check({sci2_clock_in, i2c1_data_in, cycle_meas_in1, sci2_rx_in, i2c0_clock_in,
                   fifo_uart_rx_in, key_wake_in, irq7_in, irq6_in, irq5_in, sci1_clock_in,
                   i2c1_clock_in}, 64'h6FFFF);
        end
        @(posedge clk_sys);
        #1 rst = 1'b0;
    endtask

    initial
    begin
        put(113'h0);
        void'($urandom(32'h5c93fb16));
        rst_phase();
        for (n = 0; n < 600; n++)
        begin
            if (n == 300)
                rst_phase();
            rv = {$urandom, $urandom, $urandom, $urandom};
            // Late in the run software keeps the pin-sharing rules: bit 26 is receive
            // enable, 28 timer valid, 18 serial 1 clock valid, 16 I2C 1 clock valid.
            if (n >= 450)
            begin
                rv[26] = rv[26] & ~rv[28];
                rv[18] = rv[18] & ~rv[16];
            end
            // Alternate-pin selects sit outside this block and are taken as cleared.
            put(rv[112:0]);
            @(negedge clk_sys);
            #1 predict();
            @(posedge clk_sys);
            #1 compare();
        end
        final_report();
    end

    initial
    begin
        #20000;
        miscompares++;
        final_report();
    end
endmodule

bind pom_port_mux pom_port_mux_assertions u_chk (.*);
